/* File: scsp_pkg.sv */
// Purpose: Shared constants for the serial channel service prioritizer.
// Assumes: Single 25 MHz clock, 16-bit register port with 4-bit address.
// Notes:   Timing counts are derived from step times and the clock period.
`default_nettype none
package scsp_pkg;
   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int unsigned RX_CH = 16;
   localparam int unsigned TX_CH = 16;
   localparam int unsigned CHIPS = 8;
   localparam int unsigned SRC_W = 4;
   localparam int unsigned CHIP_W = 3;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned EVT_W = 5;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned STEP_NS = 125;
   localparam int unsigned STEP_CYC_INT =
      (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 3;
   localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(STEP_CYC_INT);
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [ADDR_W-1:0] REG_OUT_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_MODEM = 4'h1;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] REG_EVT_STAT = 4'h3;
   localparam logic [ADDR_W-1:0] REG_EVT_MASK = 4'h4;
   localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

   // Status word fields.
   localparam int unsigned ST_RX = 0;
   localparam int unsigned ST_TX = 1;
   localparam int unsigned ST_CHIP = 2;
   localparam int unsigned ST_MASTER = 3;
   localparam int unsigned ST_SRC_LO = 4;
   localparam int unsigned ST_SEQ_LO = 8;

   // Event bits.
   localparam int unsigned EV_RX = 0;
   localparam int unsigned EV_TX = 1;
   localparam int unsigned EV_CHIP = 2;
   localparam int unsigned EV_SERVE = 3;
   localparam int unsigned EV_HOST = 4;

   typedef enum logic [1:0] {
      SCSP_SRC_NONE,
      SCSP_SRC_RX,
      SCSP_SRC_TX,
      SCSP_SRC_CHIP
   } scsp_src_t;

   // Steering decode for one chip select line.
   function automatic logic [CHIPS-1:0] scsp_onehot(
      input logic [CHIP_W-1:0] num);
      logic [CHIPS-1:0] v;
      v = '0;
      v[num] = 1'b1;
      return v;
   endfunction
endpackage
`default_nettype wire

/* File: scsp_enc_if.sv */
// Purpose: Carrier between the top and one priority encoder.
// Assumes: Width and index width match the encoder instance.
// Notes:   No clocking block; plain signals.
`timescale 1ns/100ps
`default_nettype none
interface scsp_enc_if #(
   parameter int unsigned N = 16,
   parameter int unsigned W = 4
);
   logic [N-1:0] req;
   logic [W-1:0] idx;
   logic any;
   modport enc (input req, output idx, output any);
   modport user (output req, input idx, input any);
endinterface
`default_nettype wire

/* File: scsp_prio_enc.sv */
// Purpose: Latching priority encoder, lowest line number wins.
// Assumes: Request lines are synchronous to the clock.
// Notes:   The latch follows the lines on every edge.
`timescale 1ns/100ps
`default_nettype none
module scsp_prio_enc #(
   parameter int unsigned N = 16,
   parameter int unsigned W = 4
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   scsp_enc_if.enc bus
);
   logic [N-1:0] req_q;

   // ***************************************************************
   // Request latch
   // ***************************************************************
   // A source that drops out is forgotten on the next edge, so a stale request
   // can win the encoder for one cycle at most.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         req_q <= '0;
      end
      else
      begin
         req_q <= bus.req;
      end
   end

   // ***************************************************************
   // Encoder
   // ***************************************************************
   always_comb
   begin
      bus.idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req_q[i])
         begin
            bus.idx = W'(i);
         end
      end
      bus.any = |req_q;
   end
endmodule // scsp_prio_enc
`default_nettype wire

/* File: scsp_top.sv */
// Purpose: Prioritizes serial channel requests onto controller conditions.
// Assumes: All inputs synchronous to ref_clk_i; one-cycle bus strobes.
// Notes:   Service sequencing models the controller branch latency.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module scsp_top
   import scsp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [RX_CH-1:0] rx_dma_req_i,
   input wire logic [TX_CH-1:0] tx_dma_req_i,
   input wire logic [CHIPS-1:0] chip_irq_i,
   input wire logic host_access_flag_i,
   input wire logic irq_acknowledge_strobe_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic rx_request_pending_flag_o,
   output logic tx_request_pending_flag_o,
   output logic chip_interrupt_pending_flag_o,
   output logic [SRC_W-1:0] serviced_source_number_o,
   output logic [CHIPS-1:0] chip_ack_o,
   output logic board_master_o,
   output logic service_start_o,
   output logic [1:0] service_class_o,
   output logic [SRC_W-1:0] service_source_o,
   output logic [DATA_W-1:0] output_control_port_o,
   output logic [DATA_W-1:0] modem_ctrl_o,
   output logic irq_o
);
   typedef enum logic [1:0] {
      SCSP_IDLE,
      SCSP_OBSERVE,
      SCSP_BRANCH
   } scsp_seq_t;

   scsp_enc_if #(.N(RX_CH), .W(SRC_W)) rx_bus ();
   scsp_enc_if #(.N(TX_CH), .W(SRC_W)) tx_bus ();
   scsp_enc_if #(.N(CHIPS), .W(CHIP_W)) ch_bus ();

   scsp_src_t src_d;
   logic [SRC_W-1:0] num_d;
   logic [CHIP_W-1:0] chip_num_q;
   scsp_seq_t seq_q;
   logic [CNT_W-1:0] cnt_q;
   logic host_q;
   logic [EVT_W-1:0] evt_q;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] mask_q;
   logic [DATA_W-1:0] status_word;
   logic any_pending;

   // ***************************************************************
   // Encoders
   // ***************************************************************
   // Request lines are driven by the serial chips themselves.
   assign rx_bus.req = rx_dma_req_i;
   assign tx_bus.req = tx_dma_req_i;
   assign ch_bus.req = chip_irq_i;

   scsp_prio_enc #(.N(RX_CH), .W(SRC_W)) u_rx_enc (
      .ref_clk_i (ref_clk_i),
      .nrst_i (nrst_i),
      .bus (rx_bus)
   );
   scsp_prio_enc #(.N(TX_CH), .W(SRC_W)) u_tx_enc (
      .ref_clk_i (ref_clk_i),
      .nrst_i (nrst_i),
      .bus (tx_bus)
   );
   scsp_prio_enc #(.N(CHIPS), .W(CHIP_W)) u_ch_enc (
      .ref_clk_i (ref_clk_i),
      .nrst_i (nrst_i),
      .bus (ch_bus)
   );

   // ***************************************************************
   // Source multiplexer
   // ***************************************************************
   always_comb
   begin
      src_d = SCSP_SRC_NONE;
      num_d = '0;
      if (rx_bus.any)
      begin
         src_d = SCSP_SRC_RX;
         num_d = rx_bus.idx;
      end
      else if (tx_bus.any)
      begin
         src_d = SCSP_SRC_TX;
         num_d = tx_bus.idx;
      end
      else if (ch_bus.any)
      begin
         src_d = SCSP_SRC_CHIP;
         num_d = {1'b0, ch_bus.idx};
      end
   end

   assign any_pending = rx_request_pending_flag_o
      | tx_request_pending_flag_o
      | chip_interrupt_pending_flag_o;

   // ***************************************************************
   // Condition outputs
   // ***************************************************************
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rx_request_pending_flag_o <= 1'b0;
         tx_request_pending_flag_o <= 1'b0;
         chip_interrupt_pending_flag_o <= 1'b0;
         serviced_source_number_o <= '0;
         service_class_o <= SCSP_SRC_NONE;
         chip_num_q <= '0;
      end
      else
      begin
         rx_request_pending_flag_o <= rx_bus.any;
         tx_request_pending_flag_o <= tx_bus.any;
         chip_interrupt_pending_flag_o <= ch_bus.any;
         serviced_source_number_o <= num_d;
         service_class_o <= src_d;
         chip_num_q <= ch_bus.idx;
      end
   end

   // ***************************************************************
   // Acknowledge steering
   // ***************************************************************
   // Decoding from the latched chip number avoids a glitch on the
   // wrong chip while the encoder is changing.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         chip_ack_o <= '0;
      end
      else if (irq_acknowledge_strobe_i && chip_interrupt_pending_flag_o)
      begin
         chip_ack_o <= scsp_onehot(chip_num_q);
      end
      else
      begin
         chip_ack_o <= '0;
      end
   end

   // ***************************************************************
   // Bus mastership
   // ***************************************************************
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         host_q <= 1'b1;
         board_master_o <= 1'b0;
      end
      else
      begin
         host_q <= host_access_flag_i;
         board_master_o <= ~host_access_flag_i;
      end
   end

   // ***************************************************************
   // Service sequencer
   // ***************************************************************
   // The step count rounds up, so service never starts earlier than the
   // controller could branch.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         seq_q <= SCSP_IDLE;
         cnt_q <= '0;
         service_start_o <= 1'b0;
         service_source_o <= '0;
      end
      else
      begin
         service_start_o <= 1'b0;
         case (seq_q)
            SCSP_IDLE:
            begin
               if (board_master_o && any_pending)
               begin
                  seq_q <= SCSP_OBSERVE;
                  cnt_q <= STEP_CYC;
               end
            end
            SCSP_OBSERVE:
            begin
               if (!board_master_o)
               begin
                  seq_q <= SCSP_IDLE;
               end
               else if (cnt_q == CNT_ONE)
               begin
                  seq_q <= SCSP_BRANCH;
                  cnt_q <= STEP_CYC;
               end
               else
               begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            SCSP_BRANCH:
            begin
               if (!board_master_o || !any_pending)
               begin
                  seq_q <= SCSP_IDLE;
               end
               else if (cnt_q == CNT_ONE)
               begin
                  seq_q <= SCSP_IDLE;
                  service_start_o <= 1'b1;
                  service_source_o <= serviced_source_number_o;
               end
               else
               begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            default:
            begin
               seq_q <= SCSP_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Control latches
   // ***************************************************************
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         output_control_port_o <= RST_WORD;
         modem_ctrl_o <= RST_WORD;
         mask_q <= '0;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == REG_OUT_CTRL)
         begin
            output_control_port_o <= reg_wdata_i;
         end
         if (reg_addr_i == REG_MODEM)
         begin
            modem_ctrl_o <= reg_wdata_i;
         end
         if (reg_addr_i == REG_EVT_MASK)
         begin
            mask_q <= reg_wdata_i[EVT_W-1:0];
         end
      end
   end

   // ***************************************************************
   // Events and interrupt
   // ***************************************************************
   always_comb
   begin
      evt_set = '0;
      evt_set[EV_RX] = rx_bus.any & ~rx_request_pending_flag_o;
      evt_set[EV_TX] = tx_bus.any & ~tx_request_pending_flag_o;
      evt_set[EV_CHIP] = ch_bus.any & ~chip_interrupt_pending_flag_o;
      evt_set[EV_SERVE] = service_start_o;
      evt_set[EV_HOST] = host_access_flag_i & ~host_q;
   end

   // A set arriving with the clearing read survives the read.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         evt_q <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         if (reg_rd_i && reg_addr_i == REG_EVT_STAT)
         begin
            evt_q <= evt_set;
            irq_o <= |(evt_set & mask_q);
         end
         else
         begin
            evt_q <= evt_q | evt_set;
            irq_o <= |((evt_q | evt_set) & mask_q);
         end
      end
   end

   // ***************************************************************
   // Read port
   // ***************************************************************
   always_comb
   begin
      status_word = '0;
      status_word[ST_RX] = rx_request_pending_flag_o;
      status_word[ST_TX] = tx_request_pending_flag_o;
      status_word[ST_CHIP] = chip_interrupt_pending_flag_o;
      status_word[ST_MASTER] = board_master_o;
      status_word[ST_SRC_LO +: SRC_W] = serviced_source_number_o;
      status_word[ST_SEQ_LO +: 2] = seq_q;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         reg_rdata_o <= RST_WORD;
      end
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            REG_OUT_CTRL: reg_rdata_o <= output_control_port_o;
            REG_MODEM: reg_rdata_o <= modem_ctrl_o;
            REG_STATUS: reg_rdata_o <= status_word;
            REG_EVT_STAT: reg_rdata_o <= {{(DATA_W-EVT_W){1'b0}}, evt_q};
            REG_EVT_MASK: reg_rdata_o <= {{(DATA_W-EVT_W){1'b0}}, mask_q};
            default: reg_rdata_o <= RST_WORD;
         endcase
      end
      else
      begin
         reg_rdata_o <= RST_WORD;
      end
   end
endmodule // scsp_top
`default_nettype wire

/* File: scsp_props.sv */
// Purpose: Port-level assertions for the service prioritizer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Request pipelines are rebuilt here to time the flags.
`timescale 1ns/100ps
`default_nettype none
module scsp_props
   import scsp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [RX_CH-1:0] rx_dma_req_i,
   input wire logic [TX_CH-1:0] tx_dma_req_i,
   input wire logic [CHIPS-1:0] chip_irq_i,
   input wire logic host_access_flag_i,
   input wire logic irq_acknowledge_strobe_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic rx_request_pending_flag_o,
   input wire logic tx_request_pending_flag_o,
   input wire logic chip_interrupt_pending_flag_o,
   input wire logic [SRC_W-1:0] serviced_source_number_o,
   input wire logic [CHIPS-1:0] chip_ack_o,
   input wire logic board_master_o,
   input wire logic service_start_o,
   input wire logic [DATA_W-1:0] output_control_port_o
);
   // ***************************************************************
   // Helpers
   // ***************************************************************
   logic [1:0] up_q;
   logic [RX_CH-1:0] r1_q, r2_q;
   logic [TX_CH-1:0] t1_q, t2_q;
   logic [CHIPS-1:0] c1_q, c2_q;
   logic rxf, txf, chf, any, arm;
   logic [SRC_W-1:0] num;
   assign rxf = rx_request_pending_flag_o;
   assign txf = tx_request_pending_flag_o;
   assign chf = chip_interrupt_pending_flag_o;
   assign num = serviced_source_number_o;
   assign any = rxf | txf | chf;
   // The flag, number, ack and master checks wait until the two-stage pipe has refilled after reset.
   assign arm = up_q == 2'h3;

   function automatic logic [3:0] lowest(input logic [15:0] v);
      lowest = 4'h0;
      for (int k = 15; k >= 0; k--)
         if (v[k])
            lowest = 4'(k);
   endfunction

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         up_q <= 2'h0;
         {r1_q, r2_q, t1_q, t2_q, c1_q, c2_q} <= '0;
      end
      else
      begin
         up_q <= arm ? up_q : up_q + 2'h1;
         {r1_q, r2_q} <= {rx_dma_req_i, r1_q};
         {t1_q, t2_q} <= {tx_dma_req_i, t1_q};
         {c1_q, c2_q} <= {chip_irq_i, c1_q};
      end
   end

   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_rx;
      arm |-> rxf == |r2_q;
   endproperty
   a_rx: assert property (p_rx) else $error("rx flag wrong");
   property p_tx;
      arm |-> txf == |t2_q;
   endproperty
   a_tx: assert property (p_tx) else $error("tx flag wrong");
   property p_chip;
      arm |-> chf == |c2_q;
   endproperty
   a_chip: assert property (p_chip) else $error("chip flag wrong");
   property p_prio_rx;
      arm && |r2_q |-> num == lowest(r2_q);
   endproperty
   a_prio_rx: assert property (p_prio_rx) else $error("rx number");
   property p_prio_tx;
      arm && r2_q == '0 && |t2_q |-> num == lowest(t2_q);
   endproperty
   a_prio_tx: assert property (p_prio_tx) else $error("tx number");
   property p_prio_chip;
      arm && {r2_q, t2_q} == '0 && |c2_q |-> num == lowest(16'(c2_q));
   endproperty
   a_prio_chip: assert property (p_prio_chip) else $error("chip num");
   property p_none;
      arm && {r2_q, t2_q, c2_q} == '0 |-> !any && num == 4'h0;
   endproperty
   a_none: assert property (p_none) else $error("idle flags");
   property p_ack;
      arm |-> chip_ack_o == (($past(irq_acknowledge_strobe_i) && $past(chf))
         ? 8'(8'h01 << lowest(16'($past(c2_q)))) : 8'h00);
   endproperty
   a_ack: assert property (p_ack) else $error("ack steering");
   property p_master;
      arm |-> board_master_o == !$past(host_access_flag_i);
   endproperty
   a_master: assert property (p_master) else $error("master");
   property p_gap;
      service_start_o |=> !service_start_o [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("branch step short");
   property p_lat;
      $rose(any) && board_master_o ##1 (any && board_master_o) [*8]
         |=> service_start_o;
   endproperty
   a_lat: assert property (p_lat) else $error("service late");
   property p_oc;
      reg_wr_i && reg_addr_i == REG_OUT_CTRL
         |=> output_control_port_o == $past(reg_wdata_i);
   endproperty
   a_oc: assert property (p_oc) else $error("control port");
   c_serve: cover property (service_start_o);
   c_ack: cover property (chip_ack_o != 8'h00);
   c_host: cover property (!board_master_o && any);
endmodule // scsp_props

bind scsp_top scsp_props u_props (.ref_clk_i, .nrst_i, .rx_dma_req_i,
   .tx_dma_req_i, .chip_irq_i, .host_access_flag_i,
   .irq_acknowledge_strobe_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .rx_request_pending_flag_o, .tx_request_pending_flag_o,
   .chip_interrupt_pending_flag_o, .serviced_source_number_o, .chip_ack_o,
   .board_master_o, .service_start_o, .output_control_port_o);
`default_nettype wire

/* File: scsp_chip_model.sv */
// Purpose: Behavioural set of serial chips facing the prioritizer.
// Assumes: Requests follow the bench's wishes one edge later.
// Notes:   An interrupt stays up until the chip is acknowledged.
`timescale 1ns/100ps
`default_nettype none
module scsp_chip_model
   import scsp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [RX_CH-1:0] rx_want_i,
   input wire logic [TX_CH-1:0] tx_want_i,
   input wire logic [CHIPS-1:0] fault_i,
   input wire logic [CHIPS-1:0] chip_ack_i,
   output logic [RX_CH-1:0] rx_req_o,
   output logic [TX_CH-1:0] tx_req_o,
   output logic [CHIPS-1:0] irq_o
);
   // ***************************************************************
   // Chips
   // ***************************************************************
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         {rx_req_o, tx_req_o, irq_o} <= '0;
      end
      else
      begin
         rx_req_o <= rx_want_i;
         tx_req_o <= tx_want_i;
         // Acknowledge wins over a fault in the same cycle; a fault still held after it re-latches.
         irq_o <= (irq_o | fault_i) & ~chip_ack_i;
      end
   end
endmodule // scsp_chip_model
`default_nettype wire

/* File: scsp_top_tb_top.sv */
// Purpose: Self-checking bench for the service prioritizer.
// Assumes: Chip model in front of the request inputs.
// Notes:   Reads and services are scored from expectation queues.
`timescale 1ns/100ps
`default_nettype none
module scsp_top_tb_top
   import scsp_pkg::*;
;
   // ***************************************************************
   // Bench
   // ***************************************************************
   logic ref_clk_i, nrst_i, host_access_flag_i, irq_acknowledge_strobe_i;
   logic reg_wr_i, reg_rd_i, rd_q, service_start_o, board_master_o, irq_o;
   logic rx_request_pending_flag_o, tx_request_pending_flag_o;
   logic chip_interrupt_pending_flag_o;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, output_control_port_o;
   logic [DATA_W-1:0] modem_ctrl_o, sq[$];
   logic [SRC_W-1:0] serviced_source_number_o, service_source_o;
   logic [1:0] service_class_o;
   logic [RX_CH-1:0] rx_dma_req_i, tx_dma_req_i, rxw, txw;
   logic [CHIPS-1:0] chip_irq_i, chip_ack_o, flt;
   logic [31:0] rq[$];
   logic [3:0] ra[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
   int fails, checks, cyc;

   scsp_top u_dut (.ref_clk_i, .nrst_i, .rx_dma_req_i, .tx_dma_req_i,
      .chip_irq_i, .host_access_flag_i, .irq_acknowledge_strobe_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .rx_request_pending_flag_o, .tx_request_pending_flag_o,
      .chip_interrupt_pending_flag_o, .serviced_source_number_o,
      .chip_ack_o, .board_master_o, .service_start_o, .service_class_o,
      .service_source_o, .output_control_port_o, .modem_ctrl_o, .irq_o);
   scsp_chip_model u_chips (.ref_clk_i, .nrst_i, .rx_want_i(rxw),
      .tx_want_i(txw), .fault_i(flt), .chip_ack_i(chip_ack_o),
      .rx_req_o(rx_dma_req_i), .tx_req_o(tx_dma_req_i), .irq_o(chip_irq_i));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [3:0] low16(input logic [15:0] v);
      low16 = 4'h0;
      for (int k = 15; k >= 0; k--)
         if (v[k])
            low16 = 4'(k);
   endfunction

   task automatic cyc_n(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] m);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      rq.push_back({m, e});
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
   endtask

   // Drops all requests, holds the acknowledge for 40 cycles, then checks every flag is clear.
   task automatic quiet();
      @(posedge ref_clk_i);
      rxw <= '0;
      txw <= '0;
      irq_acknowledge_strobe_i <= 1'b1;
      cyc_n(40);
      irq_acknowledge_strobe_i <= 1'b0;
      cyc_n(12);
      chk(16'({rx_request_pending_flag_o, tx_request_pending_flag_o,
         chip_interrupt_pending_flag_o, serviced_source_number_o}), 0);
   endtask

   always @(posedge ref_clk_i)
   begin : mon
      logic [31:0] ent;
      rd_q <= reg_rd_i;
      cyc++;
      if (rd_q)
      begin
         ent = rq.pop_front();
         chk(reg_rdata_o & ent[31:16], ent[15:0]);
      end
      if (service_start_o && sq.size() > 0)
         chk(16'(service_source_o), sq.pop_front());
      if (cyc > 6000)
      begin
         fails++;
         wrap_up();
      end
   end

   initial
   begin
      logic [15:0] r, t, x;
      logic [7:0] e;
      int n;
      {nrst_i, host_access_flag_i, irq_acknowledge_strobe_i} = '0;
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, rxw, txw, flt} = '0;
      void'($urandom(32'h87f90c34));
      cyc_n(16);
      nrst_i <= 1'b1;
      foreach (ra[j])
         rd_reg(ra[j], (j == 2) ? 16'h0008 : 16'h0000, 16'hffff);
      x = 16'($urandom);
      wr_reg(REG_OUT_CTRL, x);
      wr_reg(REG_MODEM, ~x);
      wr_reg(REG_EVT_MASK, 16'hffff);
      wr_reg(REG_STATUS, 16'hffff);
      wr_reg(4'hf, 16'hffff);
      rd_reg(REG_MODEM, ~x, 16'hffff);
      rd_reg(REG_EVT_MASK, 16'h001f, 16'hffff);
      rd_reg(REG_STATUS, 16'h0008, 16'hffff);
      chk(output_control_port_o, x);
      chk(modem_ctrl_o, ~x);
      wr_reg(REG_EVT_MASK, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         r = i[0] ? 16'($urandom) | 16'h8000 : 16'h0;
         t = i[1] ? 16'($urandom) | 16'h8000 : 16'h0;
         e = i[2] ? 8'($urandom) | 8'h80 : 8'h0;
         x = |r ? low16(r) : |t ? low16(t) : low16(16'(e));
         @(posedge ref_clk_i);
         {rxw, txw, flt} <= {r, t, e};
         if (i != 0)
            sq.push_back(x);
         @(posedge ref_clk_i);
         flt <= 8'h0;
         cyc_n(20);
         chk(16'({rx_request_pending_flag_o, tx_request_pending_flag_o,
            chip_interrupt_pending_flag_o, serviced_source_number_o}),
            16'({|r, |t, |e, x[3:0]}));
         chk(16'(service_class_o), 16'(|r ? SCSP_SRC_RX : |t ? SCSP_SRC_TX
            : |e ? SCSP_SRC_CHIP : SCSP_SRC_NONE));
         rd_reg(REG_STATUS, 16'({x[3:0], 1'b1, |e, |t, |r}), 16'h00ff);
         quiet();
      end
      @(posedge ref_clk_i);
      flt <= 8'h24;
      @(posedge ref_clk_i);
      flt <= 8'h0;
      for (int j = 0; j < 2; j++)
      begin
         cyc_n(4);
         irq_acknowledge_strobe_i <= 1'b1;
         @(posedge ref_clk_i);
         irq_acknowledge_strobe_i <= 1'b0;
         #1 chk(16'(chip_ack_o), j ? 16'h0020 : 16'h0004);
      end
      quiet();
      @(posedge ref_clk_i);
      rxw <= 16'h0008;
      sq.push_back(16'h3);
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (!service_start_o && n < 30);
      chk(16'(n), 16'(5 + 2 * STEP_CYC));
      host_access_flag_i <= 1'b1;
      cyc_n(1);
      #1 chk(16'(board_master_o), 16'h0);
      n = 0;
      cyc_n(1);
      repeat (30)
      begin
         @(posedge ref_clk_i);
         n += service_start_o;
      end
      chk(16'(n), 16'h0);
      host_access_flag_i <= 1'b0;
      sq.push_back(16'h3);
      cyc_n(25);
      quiet();
      rd_reg(REG_EVT_STAT, 16'h0, 16'h0);
      @(posedge ref_clk_i);
      txw <= 16'h0100;
      cyc_n(6);
      chk(16'(irq_o), 16'h0);
      wr_reg(REG_EVT_MASK, 16'h0002);
      cyc_n(2);
      chk(16'(irq_o), 16'h1);
      rd_reg(REG_EVT_STAT, 16'h0002, 16'h0002);
      cyc_n(3);
      chk(16'(irq_o), 16'h0);
      chk(16'(sq.size()), 16'h0);
      wrap_up();
   end
endmodule // scsp_top_tb_top
`default_nettype wire
